// [design/foc_pkg.sv]
// constants for the flow output conditioning block
// assumes a 100 MHz clock and a plain byte-addressed register port with word-aligned offsets
`default_nettype none
package foc_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int MEAS_MS = 80;
  localparam int MEAS_CYC = MEAS_MS * (CLK_HZ / 1000);
  localparam int CONFIRM_S = 5;
  localparam int CONFIRM_CYC = CONFIRM_S * CLK_HZ;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_FULL = 8'h04;
  localparam logic [7:0] A_CUT = 8'h08;
  localparam logic [7:0] A_SP1 = 8'h0C;
  localparam logic [7:0] A_SP2 = 8'h10;
  localparam logic [7:0] A_FMAX = 8'h14;
  localparam logic [7:0] A_KFAC = 8'h18;
  localparam logic [7:0] A_DOFF = 8'h1C;
  localparam logic [7:0] A_PMAX = 8'h20;
  localparam logic [7:0] A_AVGN = 8'h24;
  localparam logic [7:0] A_UNLOCK = 8'h28;
  localparam logic [7:0] A_PIN = 8'h2C;
  localparam logic [7:0] A_CUNLOCK = 8'h30;
  localparam logic [7:0] A_BUSADR = 8'h34;
  localparam logic [7:0] A_STATUS = 8'h38;
  localparam logic [7:0] A_FLOW = 8'h3C;
  localparam logic [7:0] A_TOT_LO = 8'h40;
  localparam logic [7:0] A_TOT_HI = 8'h44;
  localparam logic [10:0] CTRL_RST = 11'h000;
  localparam logic [31:0] FULL_RST = 32'h0000_00B4;
  localparam logic [31:0] CUT_RST = 32'h0000_0001;
  localparam logic [31:0] FMAX_RST = 32'h0000_03E8;
  localparam logic [31:0] FMAX_MIN = 32'h0000_007D;
  localparam logic [31:0] FMAX_MAX = 32'h0000_7D00;
  localparam logic [31:0] CUT_MAX = 32'h0000_000A;
  localparam logic [31:0] KFAC_RST = 32'h0000_0100;
  localparam logic [31:0] PMAX_RST = 32'h0000_00B4;
  localparam logic [31:0] AVGN_RST = 32'h0000_0014;
  localparam logic [31:0] AVGN_MIN = 32'h0000_000A;
  localparam logic [31:0] AVGN_MAX = 32'h0000_0064;
  localparam logic [31:0] UA_ZERO = 32'h0000_0FA0;
  localparam logic [31:0] UA_SPAN = 32'h0000_3E80;
  localparam logic [31:0] UA_OVER = 32'h0000_5DC0;
  localparam logic [31:0] MV_SPAN = 32'h0000_2710;
  localparam logic [31:0] MV_OVER = 32'h0000_2EE0;
  localparam logic [31:0] PIPE_MMS = 32'h0000_1388;
  localparam logic [31:0] PCT = 32'h0000_0064;
  localparam logic [1:0] OUT_CUR = 2'h0;
  localparam logic [1:0] OUT_VOLT = 2'h1;
  localparam logic [1:0] OUT_FREQ = 2'h2;
  typedef enum logic [1:0] {ST_LOAD = 2'b01, ST_RUN = 2'b10} foc_state_t;
endpackage : foc_pkg
`default_nettype wire

// [design/foc_top.sv]
// flow conditioning, output scaling, relays, totalizer and parameter guard
// assumes flow samples and sound speed come from echo logic on clk
`timescale 1ns/100ps
`default_nettype none
module foc_top #(
  parameter int MEAS_CYC = foc_pkg::MEAS_CYC,
  parameter int CONFIRM_CYC = foc_pkg::CONFIRM_CYC,
  parameter logic [15:0] CORR_CODE = 16'h1234 // arbitrary value
) (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  input wire logic raw_valid, // new measured flow
  input wire logic signed [31:0] raw_flow, // measured flow, l/min
  input wire logic [15:0] sound_speed, // sound speed, m/s
  input wire logic [47:0] nv_total_in, // stored totalizer
  input wire logic key_p, // P key pin
  input wire logic key_up, // up key pin
  input wire logic key_down, // down key pin
  input wire logic power_ok, // supply good pin
  output logic meas_start, // start a measurement
  output logic relay1, // relay 1 drive
  output logic relay2, // relay 2 drive
  output logic [2:0] out_sel, // current, voltage, frequency
  output logic [15:0] out_level, // uA or mV code
  output logic freq_out, // frequency output
  output logic overflow, // overflow indication
  output logic alert, // supply fail alert
  output logic [31:0] disp_value, // display value
  output logic [3:0] disp_unit, // display unit code
  output logic nv_wr, // store totalizer
  output logic [47:0] nv_data // totalizer to store
);
  // ---------------------------------------------
  // input synchronisers
  // ---------------------------------------------
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic p_prev;
  logic up_prev;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
      p_prev <= 1'b0;
      up_prev <= 1'b0;
    end else begin
      sync_a <= {power_ok, key_down, key_up, key_p};
      sync_b <= sync_a;
      p_prev <= sync_b[0];
      up_prev <= sync_b[1];
    end
  end
  logic p_rise;
  logic up_rise;
  assign p_rise = sync_b[0] & ~p_prev;
  assign up_rise = sync_b[1] & ~up_prev;
  // ---------------------------------------------
  // parameters with confirm window
  // ---------------------------------------------
  logic [10:0] ctrl;
  logic [31:0] full, cut, sp1, sp2, fmax, kfac, doff, pmax, avgn;
  logic [15:0] pin;
  logic [7:0] busadr;
  logic unlocked, corr_ok, pend_v;
  logic [7:0] pend_a;
  logic [31:0] pend_d;
  logic [31:0] pend_t;
  logic is_corr, is_param, wr_ok;
  assign is_corr = (addr == foc_pkg::A_KFAC) || (addr == foc_pkg::A_DOFF);
  // only word-aligned offsets, so a stray byte address never lands in the bus address slot
  assign is_param = (addr[1:0] == 2'h0) &&
                    ((addr <= foc_pkg::A_AVGN) || (addr == foc_pkg::A_PIN) || (addr == foc_pkg::A_BUSADR));
  assign wr_ok = wr && is_param && (!ctrl[9] || unlocked) && (!is_corr || corr_ok);
  function automatic logic [31:0] lim(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    lim = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : lim
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_v <= 1'b0;
      pend_a <= 8'h00;
      pend_d <= 32'h0;
      pend_t <= 32'h0;
      unlocked <= 1'b0;
      corr_ok <= 1'b0;
    end else begin
      if (wr_ok) begin
        pend_v <= 1'b1;
        pend_a <= addr;
        pend_d <= wdata;
        pend_t <= 32'h0;
      end else if (pend_v && (p_rise || pend_t >= CONFIRM_CYC - 1)) begin
        pend_v <= 1'b0;
        unlocked <= 1'b0;
        corr_ok <= 1'b0;
      end else if (pend_v) begin
        pend_t <= pend_t + 32'h1;
      end
      // an unlock in the cycle of a commit still takes
      if (wr && addr == foc_pkg::A_UNLOCK && wdata[15:0] == pin) unlocked <= 1'b1;
      if (wr && addr == foc_pkg::A_CUNLOCK && wdata[15:0] == CORR_CODE) corr_ok <= 1'b1;
    end
  end
  logic commit;
  assign commit = pend_v && p_rise && !wr_ok;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= foc_pkg::CTRL_RST;
      full <= foc_pkg::FULL_RST;
      cut <= foc_pkg::CUT_RST;
      sp1 <= 32'h0;
      sp2 <= 32'h0;
      fmax <= foc_pkg::FMAX_RST;
      kfac <= foc_pkg::KFAC_RST;
      doff <= 32'h0;
      pmax <= foc_pkg::PMAX_RST;
      avgn <= foc_pkg::AVGN_RST;
      pin <= 16'h0;
      busadr <= 8'h00;
    end else if (commit) begin
      unique case (pend_a)
        foc_pkg::A_CTRL: ctrl <= {pend_d[10:2], (pend_d[1:0] == 2'h3) ? foc_pkg::OUT_CUR : pend_d[1:0]};
        foc_pkg::A_FULL: full <= (pend_d == 32'h0) ? 32'h1 : pend_d;
        foc_pkg::A_CUT: cut <= lim(pend_d, 32'h0, foc_pkg::CUT_MAX);
        foc_pkg::A_SP1: sp1 <= pend_d;
        foc_pkg::A_SP2: sp2 <= pend_d;
        foc_pkg::A_FMAX: fmax <= lim(pend_d, foc_pkg::FMAX_MIN, foc_pkg::FMAX_MAX);
        foc_pkg::A_KFAC: kfac <= pend_d;
        foc_pkg::A_DOFF: doff <= pend_d;
        foc_pkg::A_PMAX: pmax <= (pend_d == 32'h0) ? 32'h1 : pend_d;
        foc_pkg::A_AVGN: avgn <= lim(pend_d, foc_pkg::AVGN_MIN, foc_pkg::AVGN_MAX);
        foc_pkg::A_PIN: pin <= {pend_d[15:12] > 4'h9 ? 4'h9 : pend_d[15:12], pend_d[11:0]};
        default: busadr <= pend_d[7:0];
      endcase
    end
  end
  // ---------------------------------------------
  // measurement pacing
  // ---------------------------------------------
  logic [31:0] meas_cnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meas_cnt <= 32'h0;
      meas_start <= 1'b0;
    end else begin
      meas_start <= (meas_cnt == MEAS_CYC - 1);
      meas_cnt <= (meas_cnt == MEAS_CYC - 1) ? 32'h0 : meas_cnt + 32'h1;
    end
  end
  // ---------------------------------------------
  // flow chain: correct, average, invert, cut off
  // ---------------------------------------------
  logic signed [31:0] corr, avg, flow;
  logic v1, v2, v3;
  logic signed [63:0] kprod, oprod;
  assign kprod = raw_flow * $signed(kfac);
  assign oprod = $signed(doff) * raw_flow;
  logic signed [31:0] nxt_avg, inv;
  logic [31:0] absf;
  logic [63:0] cutlim;
  assign nxt_avg = avg + (corr - avg) / $signed(avgn);
  assign inv = ctrl[3] ? -avg : avg;
  assign absf = inv[31] ? 32'(-inv) : 32'(inv);
  assign cutlim = full * cut;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      corr <= 32'sh0;
      avg <= 32'sh0;
      flow <= 32'sh0;
      v1 <= 1'b0;
      v2 <= 1'b0;
      v3 <= 1'b0;
    end else begin
      v1 <= raw_valid;
      v2 <= v1;
      v3 <= v2;
      if (raw_valid) corr <= 32'(kprod >>> 8) + 32'(oprod / $signed({32'h0, pmax}));
      if (v1) avg <= nxt_avg;
      if (v2) flow <= ({32'h0, absf} * 64'(foc_pkg::PCT) < cutlim) ? 32'sh0 : inv;
    end
  end
  // ---------------------------------------------
  // relays and output scaling
  // ---------------------------------------------
  logic neg, over;
  assign neg = flow[31];
  assign over = !neg && (32'(flow) > full);
  logic [31:0] ua, mv, fhz;
  assign ua = foc_pkg::UA_ZERO + 32'((64'(foc_pkg::UA_SPAN) * 64'(32'(flow))) / 64'(full));
  assign mv = 32'((64'(foc_pkg::MV_SPAN) * 64'(32'(flow))) / 64'(full));
  assign fhz = 32'((64'(fmax) * 64'(32'(flow))) / 64'(full));
  logic [31:0] next_f;
  assign next_f = neg ? 32'h0 : (over ? fmax : fhz);
  logic [31:0] facc, ftgt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      relay1 <= 1'b0;
      relay2 <= 1'b0;
      out_sel <= 3'b001;
      out_level <= 16'h0;
      overflow <= 1'b0;
    end else begin
      relay1 <= (sp1 != 32'h0) && !neg && (32'(flow) > sp1);
      relay2 <= (sp2 != 32'h0) && !neg && (32'(flow) > sp2);
      out_sel <= 3'b001 << ctrl[1:0];
      overflow <= over;
      unique case (ctrl[1:0])
        foc_pkg::OUT_CUR: out_level <= 16'(neg ? foc_pkg::UA_ZERO : (over ? foc_pkg::UA_OVER : ua));
        foc_pkg::OUT_VOLT: out_level <= 16'(neg ? 32'h0 : (over ? foc_pkg::MV_OVER : mv));
        default: out_level <= 16'h0;
      endcase
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      facc <= 32'h0;
      ftgt <= 32'h0;
      freq_out <= 1'b0;
    end else begin
      ftgt <= (ctrl[1:0] == foc_pkg::OUT_FREQ) ? next_f : 32'h0;
      if (ftgt == 32'h0) begin
        facc <= 32'h0;
        freq_out <= 1'b0;
      end else if (facc + ftgt >= 32'(foc_pkg::CLK_HZ / 2)) begin
        facc <= facc + ftgt - 32'(foc_pkg::CLK_HZ / 2);
        freq_out <= ~freq_out;
      end else begin
        facc <= facc + ftgt;
      end
    end
  end
  // ---------------------------------------------
  // totalizer, restore and power-loss check
  // ---------------------------------------------
  foc_pkg::foc_state_t st;
  logic [47:0] total;
  logic pwr_fail;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= foc_pkg::ST_LOAD;
      total <= 48'h0;
      nv_wr <= 1'b0;
      nv_data <= 48'h0;
    end else begin
      nv_wr <= 1'b0;
      unique case (st)
        foc_pkg::ST_LOAD: begin
          total <= nv_total_in;
          st <= foc_pkg::ST_RUN;
        end
        foc_pkg::ST_RUN: begin
          if (ctrl[2] && up_rise) begin
            total <= 48'h0;
            nv_wr <= 1'b1;
            nv_data <= 48'h0;
          end else if (v3 && !neg && flow != 32'sh0) begin
            total <= total + 48'(32'(flow));
            nv_wr <= 1'b1;
            nv_data <= total + 48'(32'(flow));
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_fail <= 1'b0;
      alert <= 1'b0;
    end else begin
      if (ctrl[8] && !sync_b[3]) pwr_fail <= 1'b1;
      else if (sync_b[0] && sync_b[1]) pwr_fail <= 1'b0;
      alert <= pwr_fail && sync_b[3] && !(sync_b[0] && sync_b[1]);
    end
  end
  // ---------------------------------------------
  // display
  // ---------------------------------------------
  logic [31:0] uabs;
  logic [63:0] scaled;
  assign uabs = neg ? 32'h0 : 32'(flow);
  always_comb begin
    unique case (ctrl[7:4])
      4'h0: scaled = (64'(uabs) * 64'h0000_0444) >> 16;
      4'h1: scaled = 64'(uabs);
      4'h2: scaled = 64'(uabs) * 64'h3C;
      4'h3: scaled = (64'(uabs) * 64'h0000_0042) >> 16;
      4'h4: scaled = (64'(uabs) * 64'h0000_0F5C) >> 16;
      4'h5: scaled = (64'(uabs) * 64'h0000_0121) >> 16;
      4'h6: scaled = (64'(uabs) * 64'h0000_43A1) >> 16;
      4'h7: scaled = (64'(uabs) * 64'h000F_DA12) >> 16;
      4'h8: scaled = (64'(uabs) * 64'(foc_pkg::PCT)) / 64'(full);
      default: scaled = (64'(uabs) * 64'(foc_pkg::PIPE_MMS)) / 64'(pmax);
    endcase
  end
  logic [31:0] speed;
  assign speed = 32'((64'(uabs) * 64'(foc_pkg::PIPE_MMS)) / 64'(pmax));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      disp_value <= 32'h0;
      disp_unit <= 4'h0;
    end else if (ctrl[2]) begin
      disp_value <= total[31:0];
      disp_unit <= 4'h1;
    end else if (sync_b[1]) begin
      disp_value <= speed;
      disp_unit <= 4'h9;
    end else if (sync_b[2]) begin
      disp_value <= {16'h0, sound_speed};
      disp_unit <= 4'hA;
    end else begin
      disp_value <= scaled[31:0];
      disp_unit <= ctrl[7:4];
    end
  end
  // ---------------------------------------------
  // register read port
  // ---------------------------------------------
  logic addr_bad;
  assign addr_bad = ctrl[10] && (busadr == 8'h00);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 32'h0;
    end else if (rd) begin
      unique case (addr)
        foc_pkg::A_CTRL: rdata <= {21'h0, ctrl};
        foc_pkg::A_FULL: rdata <= full;
        foc_pkg::A_CUT: rdata <= cut;
        foc_pkg::A_SP1: rdata <= sp1;
        foc_pkg::A_SP2: rdata <= sp2;
        foc_pkg::A_FMAX: rdata <= fmax;
        foc_pkg::A_KFAC: rdata <= kfac;
        foc_pkg::A_DOFF: rdata <= doff;
        foc_pkg::A_PMAX: rdata <= pmax;
        foc_pkg::A_AVGN: rdata <= avgn;
        foc_pkg::A_BUSADR: rdata <= {24'h0, busadr};
        foc_pkg::A_STATUS: rdata <= {25'h0, addr_bad, pend_v, corr_ok, unlocked, pwr_fail, neg, over};
        foc_pkg::A_FLOW: rdata <= flow;
        foc_pkg::A_TOT_LO: rdata <= total[31:0];
        foc_pkg::A_TOT_HI: rdata <= {16'h0, total[47:32]};
        default: rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end
endmodule : foc_top
`default_nettype wire

// [test/flow_output_conditioning_test.sv]
// self-checking bench for the flow output conditioning block
// assumes foc_plant feeds samples and the checker is bound at the foot
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module flow_output_conditioning_test;
  logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, en = 1'b0;
  logic key_p = 1'b0, key_up = 1'b0, key_down = 1'b0, power_ok = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, disp_value;
  logic [47:0] nv_total_in = 48'h0000_0000_1234, nv_data;
  logic signed [31:0] flow_set = 32'sh0, raw_flow;
  logic [3:0] lag = 4'h9, disp_unit;
  logic raw_valid, meas_start, relay1, relay2, freq_out, overflow, alert, nv_wr;
  logic [15:0] sound_speed, out_level;
  logic [2:0] out_sel;
  logic [10:0] ctrl = 11'h000;
  int num_errors = 0, n_checks = 0, m_avg = 0, full = 180, cut = 1, sp1 = 0, f, e;
  longint m_tot = 48'h1234;
  foc_top #(.MEAS_CYC(50), .CONFIRM_CYC(200)) uut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .raw_valid(raw_valid), .raw_flow(raw_flow), .sound_speed(sound_speed),
    .nv_total_in(nv_total_in), .key_p(key_p), .key_up(key_up), .key_down(key_down), .power_ok(power_ok),
    .meas_start(meas_start), .relay1(relay1), .relay2(relay2), .out_sel(out_sel), .out_level(out_level),
    .freq_out(freq_out), .overflow(overflow), .alert(alert), .disp_value(disp_value), .disp_unit(disp_unit),
    .nv_wr(nv_wr), .nv_data(nv_data));
  foc_plant plant (.clk(clk), .arst_n(arst_n), .en(en), .lag(lag), .flow_set(flow_set),
    .meas_start(meas_start), .raw_valid(raw_valid), .raw_flow(raw_flow), .sound_speed(sound_speed));
  always #5 clk = ~clk;
  // ----------------------------------------
  // reference model of the flow chain
  // ----------------------------------------
  function automatic int mflow();
    int v;
    v = ctrl[3] ? -m_avg : m_avg;
    if ((v < 0 ? -v : v) * 100 < full * cut) v = 0;
    return v;
  endfunction : mflow
  function automatic int lvl(input int v);
    case (ctrl[1:0])
      2'h1: return v > full ? 12000 : v < 0 ? 0 : 10000 * v / full;
      2'h2: return 0;
      default: return v > full ? 24000 : v < 0 ? 4000 : 4000 + 16000 * v / full;
    endcase
  endfunction : lvl
  always @(posedge clk) begin
    if (raw_valid === 1'b1) begin
      m_avg = m_avg + (raw_flow - m_avg) / 20;
      if (mflow() > 0) m_tot = m_tot + mflow();
    end
  end
  // ----------------------------------------
  // bus and keypad tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_wr
  task automatic set(input logic [7:0] a, input logic [31:0] d);
    bus_wr(a, d);
    key_p <= 1'b1;
    cyc(5);
    key_p <= 1'b0;
    cyc(5);
  endtask : set
  task automatic setc(input logic [10:0] c);
    set(foc_pkg::A_CTRL, {21'h0, c});
    ctrl = c;
  endtask : setc
  task automatic rchk(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = 32'hFFFF_FFFF);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", x & m, rdata & m)
  endtask : rchk
  task automatic chk_out(input int n);
    repeat (n) begin
      @(posedge clk iff raw_valid === 1'b1);
      cyc(8);
      #1;
      f = mflow();
      e = lvl(f);
      `CHK("relay1", sp1 != 0 && f > sp1, relay1)
      `CHK("relay2", 1'b0, relay2)
      `CHK("overflow", f > full, overflow)
      `CHK("out_sel", 3'h1 << ctrl[1:0], out_sel)
      if (e >= 0) `CHK("out_level", e[15:0], out_level)
    end
  endtask : chk_out
  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    `CHK("out_sel", 3'h1, out_sel)
    rchk(foc_pkg::A_FULL, 180);
    rchk(foc_pkg::A_CUT, 1);
    rchk(foc_pkg::A_FMAX, 1000);
    rchk(foc_pkg::A_AVGN, 20);
    rchk(foc_pkg::A_KFAC, 32'h100);
    rchk(foc_pkg::A_TOT_LO, 32'h1234);
    rchk(8'h48, 0);
  endtask : t_reset
  task automatic t_params();
    set(foc_pkg::A_CUT, 15);
    rchk(foc_pkg::A_CUT, 10);
    set(foc_pkg::A_FMAX, 100);
    rchk(foc_pkg::A_FMAX, 125);
    set(foc_pkg::A_FMAX, 40000);
    rchk(foc_pkg::A_FMAX, 32000);
    set(foc_pkg::A_CUT, 1);
    set(foc_pkg::A_FULL, 160);
    full = 160;
    set(foc_pkg::A_SP1, 50);
    sp1 = 50;
    rchk(foc_pkg::A_SP1, 50);
    bus_wr(foc_pkg::A_SP2, 7);
    cyc(210);
    set(foc_pkg::A_SP2, 7);
    cyc(210);
    rchk(foc_pkg::A_SP2, 7);
    set(foc_pkg::A_SP2, 0);
    bus_wr(foc_pkg::A_SP2, 9);
    cyc(210);
    key_p <= 1'b1;
    cyc(5);
    key_p <= 1'b0;
    rchk(foc_pkg::A_SP2, 0);
  endtask : t_params
  task automatic t_freq();
    logic s;
    int n;
    setc(11'h00A);
    s = freq_out;
    @(posedge clk iff freq_out !== s);
    s = freq_out;
    n = 0;
    while (freq_out === s && n < 3000) begin
      @(posedge clk);
      n++;
    end
    `CHK("freq_half", 1'b1, n >= foc_pkg::CLK_HZ / 64000 && n <= foc_pkg::CLK_HZ / 64000 + 1)
  endtask : t_freq
  task automatic t_flow();
    flow_set <= 100;
    en <= 1'b1;
    chk_out(6);
    flow_set <= 1000;
    chk_out(4);
    setc(11'h001);
    chk_out(2);
    flow_set <= -2000;
    chk_out(12);
    setc(11'h002);
    chk_out(2);
    setc(11'h000);
    chk_out(2);
    lag <= 4'h2;
    en <= 1'b0;
    setc(11'h008);
    en <= 1'b1;
    chk_out(3);
    t_freq();
    en <= 1'b0;
    cyc(60);
    rchk(foc_pkg::A_TOT_LO, m_tot[31:0]);
    `CHK("nv_data", m_tot[47:0], nv_data)
  endtask : t_flow
  task automatic t_display();
    setc(11'h004);
    key_up <= 1'b1;
    cyc(6);
    key_up <= 1'b0;
    cyc(4);
    rchk(foc_pkg::A_TOT_LO, 0);
    `CHK("disp_value", 32'h0, disp_value)
    `CHK("disp_unit", 4'h1, disp_unit)
    setc(11'h050);
    `CHK("disp_unit", 4'h5, disp_unit)
    key_down <= 1'b1;
    cyc(6);
    `CHK("disp_unit", 4'hA, disp_unit)
    `CHK("disp_value", 32'h05C8, disp_value)
    key_down <= 1'b0;
  endtask : t_display
  task automatic t_guard();
    setc(11'h100);
    power_ok <= 1'b0;
    cyc(6);
    power_ok <= 1'b1;
    cyc(6);
    `CHK("alert", 1'b1, alert)
    key_p <= 1'b1;
    key_up <= 1'b1;
    cyc(6);
    key_p <= 1'b0;
    key_up <= 1'b0;
    cyc(4);
    `CHK("alert", 1'b0, alert)
    setc(11'h400);
    rchk(foc_pkg::A_STATUS, 32'h40, 32'h40);
    set(foc_pkg::A_BUSADR, 5);
    rchk(foc_pkg::A_STATUS, 32'h0, 32'h40);
    set(foc_pkg::A_KFAC, 32'h200);
    rchk(foc_pkg::A_KFAC, 32'h100);
    bus_wr(foc_pkg::A_CUNLOCK, 32'h1234);
    set(foc_pkg::A_KFAC, 32'h200);
    rchk(foc_pkg::A_KFAC, 32'h200);
    set(foc_pkg::A_PIN, 4321);
    setc(11'h200);
    set(foc_pkg::A_SP1, 77);
    rchk(foc_pkg::A_SP1, 50);
    bus_wr(foc_pkg::A_UNLOCK, 4321);
    set(foc_pkg::A_SP1, 77);
    rchk(foc_pkg::A_SP1, 77);
  endtask : t_guard
  initial begin
    cyc(12);
    arst_n <= 1'b1;
    cyc(2);
    t_reset();
    t_params();
    t_flow();
    t_display();
    t_guard();
    report_and_stop();
  end
  initial begin
    cyc(30000);
    num_errors++;
    report_and_stop();
  end
endmodule : flow_output_conditioning_test
bind foc_top foc_top_props #(.MEAS_CYC(MEAS_CYC)) u_props (.clk(clk), .arst_n(arst_n), .addr(addr), .rd(rd),
  .rdata(rdata), .raw_valid(raw_valid), .meas_start(meas_start), .out_sel(out_sel), .out_level(out_level),
  .overflow(overflow), .nv_wr(nv_wr));
`default_nettype wire

// [test/foc_plant.sv]
// plant side model: answers each measurement start seen while en is high with one flow sample
// assumes the bench sets flow, answer lag and enable
`timescale 1ns/100ps
`default_nettype none
module foc_plant (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset
  input wire logic en, // plant delivers samples
  input wire logic [3:0] lag, // answer delay in cycles
  input wire logic signed [31:0] flow_set, // flow to report
  input wire logic meas_start, // measurement request
  output logic raw_valid, // sample pulse
  output logic signed [31:0] raw_flow, // sample value
  output logic [15:0] sound_speed // medium sound speed
);
  logic [4:0] cnt;
  assign sound_speed = 16'h05C8;
  // outside the sample slot the flow bus carries garbage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      raw_valid <= 1'b0;
      raw_flow <= 32'sh0;
      cnt <= 5'h0;
    end else begin
      raw_valid <= 1'b0;
      raw_flow <= ~flow_set;
      if (meas_start && en) begin
        cnt <= {1'b0, lag} + 5'h1;
      end else if (cnt == 5'h1) begin
        raw_valid <= 1'b1;
        raw_flow <= flow_set;
        cnt <= 5'h0;
      end else if (cnt != 5'h0) begin
        cnt <= cnt - 5'h1;
      end
    end
  end
endmodule : foc_plant
`default_nettype wire

// [test/foc_top_props.sv]
// checker for the flow output conditioning block ports
// assumes it is bound to foc_top and shares its clock and reset
`timescale 1ns/100ps
`default_nettype none
module foc_top_props #(
  parameter int MEAS_CYC = 50
) (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset
  input wire logic [7:0] addr, // register address
  input wire logic rd, // read strobe
  input wire logic [31:0] rdata, // read data
  input wire logic raw_valid, // new sample
  input wire logic meas_start, // measurement start
  input wire logic [2:0] out_sel, // output type
  input wire logic [15:0] out_level, // output level
  input wire logic overflow, // overflow flag
  input wire logic nv_wr // totalizer store
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  int unsigned since;
  logic seen;
  // ----------------------------------------
  // measurement spacing
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      since <= 0;
      seen <= 1'b0;
    end else if (meas_start) begin
      since <= 0;
      seen <= 1'b1;
    end else begin
      since <= since + 1;
    end
  end
  property p_meas_period;
    meas_start && seen |-> since == MEAS_CYC - 1;
  endproperty
  a_meas_period: assert property (p_meas_period) else $error("measurement spacing off");
  property p_rdata_idle;
    !$past(rd) |-> rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_rdata_unmapped;
    rd && addr == 8'h48 |=> rdata == 32'h0000_0000;
  endproperty
  a_rdata_unmapped: assert property (p_rdata_unmapped) else $error("unmapped read not zero");
  property p_sel_onehot;
    $onehot(out_sel);
  endproperty
  a_sel_onehot: assert property (p_sel_onehot) else $error("output select not one-hot");
  property p_freq_quiet;
    out_sel == 3'h4 |-> out_level == 16'h0000;
  endproperty
  a_freq_quiet: assert property (p_freq_quiet) else $error("analog level in frequency mode");
  property p_over_cur;
    raw_valid ##4 (overflow && out_sel == 3'h1) |-> out_level == 16'h5DC0;
  endproperty
  a_over_cur: assert property (p_over_cur) else $error("overflow current wrong");
  property p_over_volt;
    raw_valid ##4 (overflow && out_sel == 3'h2) |-> out_level == 16'h2EE0;
  endproperty
  a_over_volt: assert property (p_over_volt) else $error("overflow voltage wrong");
  property p_nv_pulse;
    nv_wr |=> !nv_wr;
  endproperty
  a_nv_pulse: assert property (p_nv_pulse) else $error("store pulse too long");
endmodule : foc_top_props
`default_nettype wire
